// ===== rtl/mcsc_cpu_div.sv
// Purpose: divides main system clock ticks into cpu clock ticks
// Assumes: main_tick is a one-cycle enable at the main system clock rate
// Notes: new code takes effect at the next wrap, so no short cpu period appears
module mcsc_cpu_div
  import mcsc_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic main_tick,
  input wire mcsc_div_t div_code,
  // output
  output logic cpu_tick
);

  logic [3:0] cnt_q; // tick counter within one cpu period
  logic [3:0] cnt_d;
  logic [3:0] limit_q; // period minus one, latched at wrap
  logic [3:0] limit_d;
  logic [3:0] new_limit; // period minus one from the current code
  logic wrap; // last tick of the period
  logic cpu_tick_d;

  // 2^code minus one; code is kept legal by the register file
  assign new_limit = 4'((5'h01 << div_code) - 5'h01); // [R9]
  assign wrap = main_tick && (cnt_q == limit_q);
  assign cnt_d = wrap ? 4'h0 : (main_tick ? 4'(cnt_q + 4'h1) : cnt_q);
  assign limit_d = wrap ? new_limit : limit_q;
  assign cpu_tick_d = wrap;

  // counter and latched ratio
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_q <= 4'h0;
      limit_q <= 4'h1;
      cpu_tick <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      limit_q <= limit_d;
      cpu_tick <= cpu_tick_d;
    end
  end

endmodule : mcsc_cpu_div

// ===== rtl/mcsc_defines.svh
// Purpose: offsets, field positions, reset values and timing counts of the main clock source control
// Assumes: 32-bit AHB-Lite register words, 200 MHz hclk
// Notes: included by its bare name
`ifndef MCSC_DEFINES_SVH
`define MCSC_DEFINES_SVH

// register byte offsets
`define MCSC_OFF_PIN_MODE 8'h00
`define MCSC_OFF_HS_OSC 8'h04
`define MCSC_OFF_SRC_SEL 8'h08
`define MCSC_OFF_CPU_DIV 8'h0c
`define MCSC_OFF_INT_OSC 8'h10
`define MCSC_OFF_STANDBY 8'h14

// pin_mode_control fields
`define MCSC_BIT_OSC_PIN_SEL 0
`define MCSC_BIT_EXT_IN_SEL 1
// hs_osc_control fields
`define MCSC_BIT_HS_OSC_STOP 0
// source_select_control fields
`define MCSC_BIT_PERIPH_SRC 0
`define MCSC_BIT_MAIN_SRC 2
`define MCSC_BIT_MAIN_STATUS 5
// cpu_divider_control fields
`define MCSC_DIV_LSB 0
`define MCSC_DIV_MSB 2
`define MCSC_BIT_CPU_STATUS 4
// internal_osc_control fields
`define MCSC_BIT_IHS_STOP 0
`define MCSC_BIT_ILS_STOP 1
`define MCSC_BIT_IHS_STABLE 7
// standby status field
`define MCSC_BIT_STOP_MODE 0

// reset values and the largest legal divide code
`define MCSC_RST_HS_OSC_STOP 1'b1
`define MCSC_RST_DIV 3'h1
`define MCSC_DIV_MAX 3'h4

// timing: internal oscillator accuracy settling
`define MCSC_CLK_PERIOD_NS 5
`define MCSC_IHS_SETTLE_NS 1000
`define MCSC_IHS_SETTLE_CYC ((`MCSC_IHS_SETTLE_NS + `MCSC_CLK_PERIOD_NS - 1) / `MCSC_CLK_PERIOD_NS)

`endif

// ===== rtl/mcsc_pkg.sv
// Purpose: shared types of the main clock source control
// Assumes: constants live in mcsc_defines.svh
// Notes: one-hot state codes written out
package mcsc_pkg;

  // standby mode of the clock generator
  typedef enum logic [1:0]
  {
    MCSC_ST_RUN = 2'b01,
    MCSC_ST_STOP = 2'b10
  } mcsc_mode_t;

  // cpu divide code, 000..100 legal
  typedef logic [2:0] mcsc_div_t;

endpackage : mcsc_pkg

// ===== rtl/mcsc_top.sv
// Purpose: main clock source control: pin modes, oscillator run control, source selection, cpu divide
// Assumes: oscillator clocks arrive as one-cycle tick enables synchronous to hclk
// Notes: every clock out of this block is an enable pulse, not a real clock
//
// Functional notes
// [R1] both pin bits set: external clock input mode
// [R2] ext 0, osc 1: crystal oscillation mode
// [R3] hs stop cleared enables external clock input
// [R4] software keeps pin bits while hs runs
// [R5] software waits stabilisation before using crystal
// [R6] both selects set: hs to main, peripherals
// [R7] hs main forces hs peripheral clock
// [R8] main select 0: internal to both
// [R9] cpu clock divides main by 1..16
// [R10] stop mode halts crystal and external input
// [R11] stop mode halts internal hs oscillator
// [R12] hs stop set halts crystal or input
// [R13] status bits report cpu clock source
// [R14] software checks status before stopping hs
// [R15] internal stop cleared restarts internal oscillator
// [R16] stable flag set after internal settling
// [R17] reset starts internal oscillator, selects it
// [R18] internal stop set halts internal oscillator
// [R19] software checks status before stopping internal
// [R20] software picks internal clock before stop
// [R21] low-speed clock only for watchdog, timer
// [R22] option decides low-speed oscillator stoppable
// [R23] low-speed starts at reset, drives watchdog
// [R24] reset gives port mode, hs stopped
//
// Our own choices: the register offsets and register access over AHB-Lite.
module mcsc_top
  import mcsc_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // oscillator ticks
  input wire logic hs_tick,
  input wire logic ihs_tick,
  input wire logic ils_tick,
  // standby and options
  input wire logic stop_instr,
  input wire logic stop_release,
  input wire logic ils_stoppable_opt,
  input wire logic wdt_enable_opt,
  input wire logic timer_sel_ls,
  // pin and oscillator controls
  output logic xtal_amp_en,
  output logic ext_clk_in_en,
  output logic pin1_port_en,
  output logic pin2_port_en,
  output logic ihs_osc_en,
  output logic ils_osc_en,
  // clock enables
  output logic main_clk_en,
  output logic periph_clk_en,
  output logic cpu_clk_en,
  output logic wdt_clk_en,
  output logic timer_clk_en
);

`include "mcsc_defines.svh"

  // register state
  logic ext_input_select_q; // pin mode bit, external input
  logic osc_pin_select_q; // pin mode bit, oscillator pins
  logic hs_osc_stop_q; // high-speed oscillator stop
  logic main_source_select_q; // main source request
  logic periph_source_select_q; // peripheral source request
  mcsc_div_t div_q; // cpu divide code
  logic internal_hs_stop_q; // internal oscillator stop
  logic ils_stop_q; // low-speed oscillator stop request
  logic main_clock_status_q; // applied main source, 1 = hs
  logic periph_hs_q; // applied peripheral source, 1 = hs
  logic internal_hs_stable_q; // internal accuracy settled
  logic [7:0] settle_cnt_q; // settling counter
  mcsc_mode_t mode_q; // run or stop
  mcsc_mode_t mode_d;

  // ahb address phase capture
  logic wr_pend_q; // write waiting for its data phase
  logic [7:0] wr_addr_q; // address of that write

  // decoded nets
  wire addr_phase = hsel && hready && htrans[1];
  wire wr_pin = wr_pend_q && (wr_addr_q == `MCSC_OFF_PIN_MODE);
  wire wr_hs = wr_pend_q && (wr_addr_q == `MCSC_OFF_HS_OSC);
  wire wr_src = wr_pend_q && (wr_addr_q == `MCSC_OFF_SRC_SEL);
  wire wr_div = wr_pend_q && (wr_addr_q == `MCSC_OFF_CPU_DIV);
  wire wr_int = wr_pend_q && (wr_addr_q == `MCSC_OFF_INT_OSC);
  wire mcsc_div_t wdiv = hwdata[`MCSC_DIV_MSB:`MCSC_DIV_LSB];
  // prohibited divide codes are dropped so the divider never sees them
  wire div_legal = (wdiv <= `MCSC_DIV_MAX); // [R9]
  wire in_stop = (mode_q == MCSC_ST_STOP);

  // pin mode decode
  wire ext_mode = ext_input_select_q && osc_pin_select_q; // [R1]
  wire xtal_mode = !ext_input_select_q && osc_pin_select_q; // [R2]
  // high-speed clock runs only with its pins set up, not stopped, not in stop mode
  wire hs_run = (ext_mode || xtal_mode) && !hs_osc_stop_q && !in_stop; // [R3] [R10] [R12]
  wire ihs_run = !internal_hs_stop_q && !in_stop; // [R11] [R15] [R18]
  // the low-speed oscillator ignores its stop bit unless the option allows it
  wire ils_run = !(ils_stop_q && ils_stoppable_opt); // [R22] [R23]

  // requested sources: main needs both selects, peripherals follow main_source_select
  wire main_req_hs = main_source_select_q && periph_source_select_q; // [R6] [R8]
  wire periph_req_hs = main_source_select_q; // [R7] [R8]
  // a source change is applied only once the target runs, so no tick is lost or doubled
  wire main_ok = main_req_hs ? hs_run : ihs_run;
  wire main_status_d = main_ok ? main_req_hs : main_clock_status_q;
  // hs main forces hs peripheral clock regardless of the applied peripheral state
  wire periph_hs_d = main_status_d || (periph_req_hs ? (hs_run ? 1'b1 : periph_hs_q) : (ihs_run ? 1'b0 : periph_hs_q)); // [R7]
  wire main_tick = main_clock_status_q ? (hs_tick && hs_run) : (ihs_tick && ihs_run);
  wire periph_tick = periph_hs_q ? (hs_tick && hs_run) : (ihs_tick && ihs_run);
  // low-speed ticks never reach the cpu path
  wire ls_tick = ils_tick && ils_run; // [R21]

  // settling counter of the internal oscillator
  wire settle_done = (settle_cnt_q == 8'(`MCSC_IHS_SETTLE_CYC - 1));
  wire [7:0] settle_cnt_d = !ihs_run ? 8'h00 : (settle_done ? settle_cnt_q : 8'(settle_cnt_q + 8'h01));
  wire stable_d = ihs_run && (internal_hs_stable_q || settle_done); // [R16]

  // read mux
  wire [31:0] rd_pin = {30'h0, ext_input_select_q, osc_pin_select_q};
  wire [31:0] rd_hs = {31'h0, hs_osc_stop_q};
  wire [31:0] rd_src = {26'h0, main_clock_status_q, 2'h0, main_source_select_q, 1'h0, periph_source_select_q}; // [R13]
  // no subsystem clock exists, so cpu status stays 0: cpu runs on main clock
  wire [31:0] rd_div = {27'h0, 1'b0, 1'b0, div_q}; // [R13]
  wire [31:0] rd_int = {24'h0, internal_hs_stable_q, 5'h0, ils_stop_q, internal_hs_stop_q};
  wire [31:0] rd_stb = {31'h0, in_stop};
  wire [31:0] rd_data = (haddr == `MCSC_OFF_PIN_MODE) ? rd_pin :
                        (haddr == `MCSC_OFF_HS_OSC) ? rd_hs :
                        (haddr == `MCSC_OFF_SRC_SEL) ? rd_src :
                        (haddr == `MCSC_OFF_CPU_DIV) ? rd_div :
                        (haddr == `MCSC_OFF_INT_OSC) ? rd_int :
                        (haddr == `MCSC_OFF_STANDBY) ? rd_stb : 32'h0;
  wire [31:0] hrdata_d = (addr_phase && !hwrite) ? rd_data : hrdata;

  // standby state machine
  always_comb
  begin
    mode_d = mode_q;
    case (mode_q)
      MCSC_ST_RUN:
      begin
        // stop instruction halts the high-speed and internal oscillators
        if (stop_instr)
          mode_d = MCSC_ST_STOP; // [R10] [R11]
      end
      MCSC_ST_STOP:
      begin
        // release restores the previous run settings
        if (stop_release)
          mode_d = MCSC_ST_RUN;
      end
      default:
      begin
        mode_d = MCSC_ST_RUN;
      end
    endcase
  end

  // bus front end: zero wait states, always okay
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      wr_pend_q <= addr_phase && hwrite;
      wr_addr_q <= addr_phase ? haddr : wr_addr_q;
      hrdata <= hrdata_d;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // pin mode and oscillator control bits; reset gives port mode, hs stopped
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ext_input_select_q <= 1'b0; // [R24]
      osc_pin_select_q <= 1'b0; // [R24]
      hs_osc_stop_q <= `MCSC_RST_HS_OSC_STOP; // [R24]
      internal_hs_stop_q <= 1'b0; // [R17]
      ils_stop_q <= 1'b0; // [R23]
    end
    else
    begin
      // pin bits are not guarded; software keeps them while hs runs
      if (wr_pin)
      begin
        ext_input_select_q <= hwdata[`MCSC_BIT_EXT_IN_SEL];
        osc_pin_select_q <= hwdata[`MCSC_BIT_OSC_PIN_SEL];
      end
      if (wr_hs)
        hs_osc_stop_q <= hwdata[`MCSC_BIT_HS_OSC_STOP]; // [R3] [R12]
      if (wr_int)
      begin
        internal_hs_stop_q <= hwdata[`MCSC_BIT_IHS_STOP]; // [R15] [R18]
        ils_stop_q <= hwdata[`MCSC_BIT_ILS_STOP]; // [R22]
      end
    end
  end

  // source selection and divide code; reset selects internal clock, divide by 2
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      main_source_select_q <= 1'b0; // [R17]
      periph_source_select_q <= 1'b0;
      div_q <= `MCSC_RST_DIV; // [R9]
    end
    else
    begin
      if (wr_src)
      begin
        main_source_select_q <= hwdata[`MCSC_BIT_MAIN_SRC];
        periph_source_select_q <= hwdata[`MCSC_BIT_PERIPH_SRC];
      end
      if (wr_div && div_legal)
        div_q <= wdiv; // [R9]
    end
  end

  // applied sources, stability and mode
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      main_clock_status_q <= 1'b0; // [R17]
      periph_hs_q <= 1'b0;
      internal_hs_stable_q <= 1'b0;
      settle_cnt_q <= 8'h00;
      mode_q <= MCSC_ST_RUN;
    end
    else
    begin
      main_clock_status_q <= main_status_d; // [R13]
      periph_hs_q <= periph_hs_d; // [R6] [R7] [R8]
      internal_hs_stable_q <= stable_d; // [R16]
      settle_cnt_q <= settle_cnt_d;
      mode_q <= mode_d;
    end
  end

  // registered pin, oscillator and clock enable outputs
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      xtal_amp_en <= 1'b0;
      ext_clk_in_en <= 1'b0;
      pin1_port_en <= 1'b1;
      pin2_port_en <= 1'b1;
      ihs_osc_en <= 1'b0;
      ils_osc_en <= 1'b0;
      main_clk_en <= 1'b0;
      periph_clk_en <= 1'b0;
      wdt_clk_en <= 1'b0;
      timer_clk_en <= 1'b0;
    end
    else
    begin
      xtal_amp_en <= xtal_mode && hs_run; // [R2] [R10] [R12]
      ext_clk_in_en <= ext_mode && hs_run; // [R1] [R3] [R10]
      // first pin stays a port in external mode, second only in port mode
      pin1_port_en <= !xtal_mode; // [R1]
      pin2_port_en <= !osc_pin_select_q; // [R1]
      ihs_osc_en <= ihs_run; // [R17]
      ils_osc_en <= ils_run; // [R23]
      main_clk_en <= main_tick;
      periph_clk_en <= periph_tick;
      wdt_clk_en <= ls_tick && wdt_enable_opt; // [R21] [R23]
      timer_clk_en <= ls_tick && timer_sel_ls; // [R21]
    end
  end

  // cpu clock divider
  mcsc_cpu_div u_cpu_div
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .main_tick(main_tick),
    .div_code(div_q),
    .cpu_tick(cpu_clk_en)
  );

endmodule : mcsc_top

// ===== sim/main_clock_source_control_tb_top.sv
// Purpose: register-driven test of the main clock source control
// Assumes: zero-wait ahb-lite slave, tick enables made here
// Notes: ticks run free; the design must drop ticks of stopped sources
module main_clock_source_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // bus side
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  // ticks, events, options
  logic hs_tick, ihs_tick, ils_tick, stop_instr, stop_release, ils_stoppable_opt, wdt_enable_opt, timer_sel_ls;
  // outputs
  logic xtal_amp_en, ext_clk_in_en, pin1_port_en, pin2_port_en, ihs_osc_en, ils_osc_en;
  logic main_clk_en, periph_clk_en, cpu_clk_en, wdt_clk_en, timer_clk_en;
  int bad_count = 0, checked = 0, cyc = 0, m, p, c, w, t;
  // reset values by offset 0x00..0x18, last one unmapped
  logic [31:0] rv [7] = '{32'h0, 32'h1, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0};

  assign hready = hreadyout; // single slave

  mcsc_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .hs_tick, .ihs_tick, .ils_tick, .stop_instr, .stop_release, .ils_stoppable_opt,
    .wdt_enable_opt, .timer_sel_ls, .xtal_amp_en, .ext_clk_in_en, .pin1_port_en, .pin2_port_en,
    .ihs_osc_en, .ils_osc_en, .main_clk_en, .periph_clk_en, .cpu_clk_en, .wdt_clk_en, .timer_clk_en);

  // 200 mhz clock
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  // distinct tick rates let a count tell the sources apart
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    hs_tick <= (cyc % 3 == 0);
    ihs_tick <= (cyc % 2 == 0);
    ils_tick <= (cyc % 5 == 0);
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one single transfer; waits on hready, read data taken at data-phase edge
  task automatic bus(input logic [7:0] a, input logic wr_en, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr_en;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
    repeat (3) @(posedge hclk); // let control levels follow
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    check(rd, e);
  endtask : rc

  // count enable pulses over n cycles
  task automatic cnt(input int n);
    m = 0;
    p = 0;
    c = 0;
    w = 0;
    t = 0;
    repeat (n)
    begin
      @(posedge hclk);
      m += main_clk_en;
      p += periph_clk_en;
      c += cpu_clk_en;
      w += wdt_clk_en;
      t += timer_clk_en;
    end
  endtask : cnt

  // window edges may gain or lose one pulse
  task automatic rng(input int v, input int lo, input int hi);
    check(32'(v >= lo && v <= hi), 32'h1);
  endtask : rng

  task automatic finish_test();
    if (bad_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  // hang guard, well beyond the under two thousand cycles needed
  initial
  begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    finish_test();
  end

  initial
  begin
    {hresetn, hsel, htrans, haddr, hwrite, hwdata, stop_instr, stop_release} = '0;
    // ticks have their own driver above and settle from the first edge, well inside reset
    ils_stoppable_opt = 1'b0;
    {wdt_enable_opt, timer_sel_ls} = 2'b11;
    hsize = 3'h2;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 7; i++) rc(8'(4 * i), rv[i]);
    check({ihs_osc_en, xtal_amp_en, ext_clk_in_en, pin1_port_en, pin2_port_en}, 5'h13);
    cnt(60);
    rng(m, 29, 31);
    rng(w, 11, 13);
    rng(t, 11, 13);
    repeat (200) @(posedge hclk);
    rc(8'h10, 32'h80);
    wr(8'h00, 32'h1);
    wr(8'h04, 32'h0);
    check({xtal_amp_en, ext_clk_in_en, pin1_port_en, pin2_port_en}, 4'b1000);
    // main still on internal clock and cpu never moved onto the crystal, so stopping is allowed
    wr(8'h04, 32'h1);
    check(xtal_amp_en, 1'b0);
    wr(8'h00, 32'h3);
    wr(8'h04, 32'h0);
    check({xtal_amp_en, ext_clk_in_en, pin1_port_en, pin2_port_en}, 4'b0110);
    wr(8'h08, 32'h5);
    rc(8'h08, 32'h25);
    cnt(60);
    rng(m, 19, 21);
    rng(p, 19, 21);
    // main on hs, so the internal oscillator may stop
    wr(8'h10, 32'h1);
    check(ihs_osc_en, 1'b0);
    rc(8'h10, 32'h1);
    wr(8'h10, 32'h0);
    check(ihs_osc_en, 1'b1);
    wr(8'h08, 32'h4);
    rc(8'h08, 32'h4);
    cnt(60);
    rng(m, 29, 31);
    rng(p, 19, 21);
    for (int k = 0; k <= 4; k++)
    begin
      wr(8'h0c, 32'(k));
      repeat (40) @(posedge hclk);
      cnt(160);
      rng(c, (80 >> k) - 1, (80 >> k) + 1);
    end
    wr(8'h0c, 32'h5);
    rc(8'h0c, 32'h4);
    // main select 0 with peripheral select 1: both back on the internal clock
    wr(8'h08, 32'h1);
    cnt(60);
    rng(p, 29, 31);
    timer_sel_ls <= 1'b0;
    wr(8'h10, 32'h2);
    check(ils_osc_en, 1'b1);
    cnt(60);
    rng(t, 0, 0);
    ils_stoppable_opt <= 1'b1;
    repeat (3) @(posedge hclk);
    check(ils_osc_en, 1'b0);
    cnt(60);
    rng(w, 0, 0);
    wr(8'h10, 32'h0);
    wr(8'h08, 32'h0);
    stop_instr <= 1'b1;
    @(posedge hclk);
    stop_instr <= 1'b0;
    repeat (3) @(posedge hclk);
    check({xtal_amp_en, ext_clk_in_en, ihs_osc_en}, 3'b000);
    rc(8'h14, 32'h1);
    cnt(30);
    rng(m, 0, 0);
    stop_release <= 1'b1;
    @(posedge hclk);
    stop_release <= 1'b0;
    repeat (3) @(posedge hclk);
    check({ext_clk_in_en, ihs_osc_en}, 2'b11);
    finish_test();
  end
endmodule : main_clock_source_control_tb_top

// ===== sim/mcsc_top_sva.sv
// Purpose: port-level checks of the main clock source control
// Assumes: one hclk domain, hresetn async active low
// Notes: bound to mcsc_top below its endmodule
module mcsc_top_chk
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus answer
  input wire logic hreadyout,
  input wire logic hresp,
  // ticks and events
  input wire logic hs_tick,
  input wire logic ihs_tick,
  input wire logic ils_tick,
  input wire logic stop_instr,
  input wire logic stop_release,
  input wire logic wdt_enable_opt,
  input wire logic timer_sel_ls,
  // pin and oscillator controls
  input wire logic xtal_amp_en,
  input wire logic ext_clk_in_en,
  input wire logic pin1_port_en,
  input wire logic pin2_port_en,
  input wire logic ihs_osc_en,
  // clock enables
  input wire logic main_clk_en,
  input wire logic periph_clk_en,
  input wire logic cpu_clk_en,
  input wire logic wdt_clk_en,
  input wire logic timer_clk_en
);
  timeunit 1ns;
  timeprecision 1ps;
  // single domain, so clock and disable are stated once
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_ext_pins: assert property (ext_clk_in_en |-> pin1_port_en && !pin2_port_en)
    else $error("external input mode with wrong pin roles");
  a_xtal_pins: assert property (xtal_amp_en |-> !pin1_port_en && !pin2_port_en)
    else $error("crystal running while a pin is a port");
  a_hs_exclusive: assert property (!(xtal_amp_en && ext_clk_in_en))
    else $error("crystal and external input both on");
  // enables are one cycle behind the mode change, hence the extra cycle
  a_stop_hs: assert property (stop_instr && !stop_release |=> ##1 !xtal_amp_en && !ext_clk_in_en)
    else $error("high-speed source still on in stop mode");
  a_stop_ihs: assert property (stop_instr && !stop_release |=> ##1 !ihs_osc_en)
    else $error("internal oscillator still on in stop mode");
  a_main_src: assert property (main_clk_en |-> $past(hs_tick) || $past(ihs_tick))
    else $error("main tick without a source tick");
  a_periph_src: assert property (periph_clk_en |-> $past(hs_tick) || $past(ihs_tick))
    else $error("peripheral tick without a source tick");
  a_cpu_from_main: assert property (cpu_clk_en |-> main_clk_en || $past(main_clk_en))
    else $error("cpu tick without a main tick");
  a_wdt_gate: assert property (wdt_clk_en |-> $past(ils_tick && wdt_enable_opt))
    else $error("watchdog tick not from low-speed clock");
  a_timer_gate: assert property (timer_clk_en |-> $past(ils_tick && timer_sel_ls))
    else $error("timer tick not from low-speed clock");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
endmodule : mcsc_top_chk

bind mcsc_top mcsc_top_chk u_chk (.hclk, .hresetn, .hreadyout, .hresp, .hs_tick, .ihs_tick, .ils_tick,
  .stop_instr, .stop_release, .wdt_enable_opt, .timer_sel_ls, .xtal_amp_en, .ext_clk_in_en, .pin1_port_en,
  .pin2_port_en, .ihs_osc_en, .main_clk_en, .periph_clk_en, .cpu_clk_en, .wdt_clk_en, .timer_clk_en);
